// ==== hw/dps_pkg.sv ====
/*
 * package for the port direction and display pin select block:
 * register indices, field positions, reset values and the pin carrier.
 * assumes a 32-bit apb master with a 12-bit byte address.
 */
package dps_pkg;
	localparam int unsigned ADDR_W = 12;
	// printed offsets are register indices; byte address is four times
	localparam logic [9:0] PORT0_DIR_IDX = 10'h0c1;
	localparam logic [9:0] PORT1_DIR_IDX = 10'h0c3;
	localparam logic [9:0] PORT2_DIR_IDX = 10'h0c5;
	localparam logic [9:0] PIN_SEL_IDX = 10'h0cb;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] PIN_SEL_RESET = 8'h00;
	// only bits 2..5 and 7 of the select register hold state
	localparam logic [7:0] PIN_SEL_MASK = 8'hbc;
	localparam int unsigned RED_SEL_BIT = 2;
	localparam int unsigned GREEN_SEL_BIT = 3;
	localparam int unsigned BLUE_SEL_BIT = 4;
	localparam int unsigned AUX1_SEL_BIT = 5;
	localparam int unsigned AUX2_SEL_BIT = 7;

	// one group of eight pins: level driven and its output enable
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} dps_pins_type;

	// the four shared pins of the display port, bits 2..5 of that port
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} dps_shared_type;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] dps_addr(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction
endpackage : dps_pkg

// ==== hw/dps_pin_config.sv ====
/*
 * port direction registers and display pin select register behind an
 * apb slave, with the resulting pin drive and enable for ports 0..2 and
 * for the shared display pins.
 * assumes all inputs come from logic on the same clock (port latches,
 * display signal generator, direction of the display port).
 */
// Local design decision: the APB slave port.
module dps_pin_config
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dps_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0][7:0] port_latch,
	input wire logic [3:0] shared_latch,
	input wire logic [3:0] shared_dir,
	input wire logic osd_red,
	input wire logic osd_green,
	input wire logic osd_blue,
	input wire logic display_aux_out_a,
	input wire logic display_aux_out_b,
	output dps_pkg::dps_pins_type [2:0] port_pins,
	output dps_pkg::dps_shared_type shared_pins
);
	import dps_pkg::*;

	typedef struct packed {
		logic [2:0][7:0] port_direction_reg;
		logic [7:0] display_pin_select_reg;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		dps_pins_type [2:0] pins;
		dps_shared_type shared;
	} dps_state_type;

	dps_state_type state_r;
	dps_state_type state_nxt;

	// decode: index of a direction register or -1
	function automatic int dir_index(input logic [ADDR_W-1:0] a);
		if (a == dps_addr(PORT0_DIR_IDX)) begin
			return 0;
		end else if (a == dps_addr(PORT1_DIR_IDX)) begin
			return 1;
		end else if (a == dps_addr(PORT2_DIR_IDX)) begin
			return 2;
		end else begin
			return -1;
		end
	endfunction

	logic access;
	logic is_sel;
	int didx;
	logic [7:0] sel;
	logic [7:0] wbyte;

	assign access = psel && penable;
	assign is_sel = (paddr == dps_addr(PIN_SEL_IDX));
	assign didx = dir_index(paddr);
	assign sel = state_r.display_pin_select_reg;
	assign wbyte = pwdata[7:0];

	// next state: bus answer, register writes, pin mux
	always_comb begin
		state_nxt = state_r;
		state_nxt.ready = 1'b0;
		state_nxt.slverr = 1'b0;
		// answer one cycle into the access phase; data latched with it
		if (access && !state_r.ready) begin
			state_nxt.ready = 1'b1;
			state_nxt.rdata = 32'h0000_0000;
			if (didx >= 0) begin
				state_nxt.rdata[7:0] = state_r.port_direction_reg[didx];
			end else if (is_sel) begin
				state_nxt.rdata[7:0] = sel & PIN_SEL_MASK;
			end else begin
				state_nxt.slverr = 1'b1;
			end
		end
		// write lands on the edge where pready is seen high
		if (access && state_r.ready && pwrite && pstrb[0]) begin
			if (didx >= 0) begin
				state_nxt.port_direction_reg[didx] = wbyte;
			end else if (is_sel) begin
				// bits 0, 1 and 6 never store, so they read back zero
				state_nxt.display_pin_select_reg = wbyte & PIN_SEL_MASK;
			end
		end
		// ordinary ports: latch drives, direction bit enables
		for (int p = 0; p < 3; p++) begin
			state_nxt.pins[p].out = port_latch[p];
			state_nxt.pins[p].oe = state_r.port_direction_reg[p];
		end
		// port 1 bit 0: second aux output when select bit 7 is one
		if (sel[AUX2_SEL_BIT]) begin
			state_nxt.pins[1].out[0] = display_aux_out_b;
			state_nxt.pins[1].oe[0] = 1'b1;
		end
		// shared display pins: zero picks the display signal
		state_nxt.shared.out = shared_latch;
		state_nxt.shared.oe = shared_dir;
		if (!sel[RED_SEL_BIT]) begin
			state_nxt.shared.out[0] = osd_red;
			state_nxt.shared.oe[0] = 1'b1;
		end
		if (!sel[GREEN_SEL_BIT]) begin
			state_nxt.shared.out[1] = osd_green;
			state_nxt.shared.oe[1] = 1'b1;
		end
		if (!sel[BLUE_SEL_BIT]) begin
			state_nxt.shared.out[2] = osd_blue;
			state_nxt.shared.oe[2] = 1'b1;
		end
		if (!sel[AUX1_SEL_BIT]) begin
			state_nxt.shared.out[3] = display_aux_out_a;
			state_nxt.shared.oe[3] = 1'b1;
		end
	end

	// all state in one register; reset leaves ports 0..2 inputs, select zero hands the shared pins to the display signals
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= '0;
			state_r.port_direction_reg <= {3{DIR_RESET}};
			state_r.display_pin_select_reg <= PIN_SEL_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign prdata = state_r.rdata;
	assign pready = state_r.ready;
	assign pslverr = state_r.slverr;
	assign port_pins = state_r.pins;
	assign shared_pins = state_r.shared;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence dir0_write_s;
		access && pready && pwrite && pstrb[0]
			&& paddr == dps_addr(PORT0_DIR_IDX);
	endsequence

	sequence sel_read_s;
		access && !pready && is_sel;
	endsequence

	dir_drives_oe_a: assert property (
		dir0_write_s |-> ##2 port_pins[0].oe == $past(pwdata[7:0], 2))
		else $error("port 0 enable does not follow direction write");

	dir_read_back_a: assert property (
		access && !pready && paddr == dps_addr(PORT1_DIR_IDX)
		|=> pready && prdata == {24'h000000, state_r.port_direction_reg[1]})
		else $error("direction read back wrong");

	red_select_a: assert property (
		!sel[RED_SEL_BIT] |=> shared_pins.out[0] == $past(osd_red)
			&& shared_pins.oe[0])
		else $error("red signal not on its pin");

	aux1_select_a: assert property (
		!sel[AUX1_SEL_BIT] |=> shared_pins.out[3] == $past(display_aux_out_a))
		else $error("first aux signal not on its pin");

	aux2_select_a: assert property (
		sel[AUX2_SEL_BIT] |=> port_pins[1].out[0] == $past(display_aux_out_b)
			&& port_pins[1].oe[0])
		else $error("second aux signal not on its pin");

	sel_zero_bits_a: assert property (
		sel_read_s |=> pready && prdata[6] == 1'b0 && prdata[1:0] == 2'b00)
		else $error("select register fixed bits not zero");

	latch_select_a: assert property (
		sel[GREEN_SEL_BIT] |=> shared_pins.out[1] == $past(shared_latch[1])
			&& shared_pins.oe[1] == $past(shared_dir[1]))
		else $error("shared pin not driven by port latch");

	// a select register write on the edge that accepts it
	sequence sel_write_s;
		access && pready && pwrite && pstrb[0] && is_sel;
	endsequence

	// an access phase to an address that decodes to no register
	sequence unmapped_s;
		access && !pready && didx < 0 && !is_sel;
	endsequence

	// the answer to such an access: error flag, zero data
	sequence error_answer_s;
		pready && pslverr && prdata == 32'h0000_0000;
	endsequence

	// a write whose low byte strobe is off
	sequence masked_write_s;
		access && pready && pwrite && !pstrb[0];
	endsequence

	// held reset clears every register and leaves the port 0 and port 2 pins inputs
	reset_clears_a: assert property (
		@(posedge clock) disable iff (1'b0)
		!rst_b |=> state_r.port_direction_reg == {3{DIR_RESET}}
			&& state_r.display_pin_select_reg == PIN_SEL_RESET
			&& port_pins[0].oe == 8'h00 && port_pins[2].oe == 8'h00)
		else $error("registers not cleared by reset");

	// each transfer gets exactly one cycle of pready
	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("pready held past one cycle");

	// port 1 enables above bit 0 always follow the direction register
	dir1_oe_a: assert property (
		1'b1 |=> port_pins[1].oe[7:1]
			== $past(state_r.port_direction_reg[1][7:1]))
		else $error("port 1 enable does not follow its register");

	// port 2 has no shared pin, so every enable follows its register
	dir2_oe_a: assert property (
		1'b1 |=> port_pins[2].oe
			== $past(state_r.port_direction_reg[2]))
		else $error("port 2 enable does not follow its register");

	// port 2 direction read answers with the stored byte
	dir2_read_a: assert property (
		access && !pready && paddr == dps_addr(PORT2_DIR_IDX)
		|=> pready && prdata == {24'h000000, state_r.port_direction_reg[2]})
		else $error("port 2 direction read back wrong");

	// second aux deselected: port 1 bit 0 is an ordinary port pin
	aux2_off_a: assert property (
		!sel[AUX2_SEL_BIT]
			|=> port_pins[1].out[0] == $past(port_latch[1][0])
			&& port_pins[1].oe[0] == $past(state_r.port_direction_reg[1][0]))
		else $error("port 1 bit 0 not back on its latch");

	// green pin carries the display colour while its bit is zero
	green_select_a: assert property (
		!sel[GREEN_SEL_BIT] |=> shared_pins.out[1] == $past(osd_green)
			&& shared_pins.oe[1])
		else $error("green signal not on its pin");

	// blue pin carries the display colour while its bit is zero
	blue_select_a: assert property (
		!sel[BLUE_SEL_BIT] |=> shared_pins.out[2] == $past(osd_blue)
			&& shared_pins.oe[2])
		else $error("blue signal not on its pin");

	// red deselected: its shared pin follows latch and direction
	red_latch_a: assert property (
		sel[RED_SEL_BIT] |=> shared_pins.out[0] == $past(shared_latch[0])
			&& shared_pins.oe[0] == $past(shared_dir[0]))
		else $error("red pin not handed back to its latch");

	// blue deselected: its shared pin follows latch and direction
	blue_latch_a: assert property (
		sel[BLUE_SEL_BIT] |=> shared_pins.out[2] == $past(shared_latch[2])
			&& shared_pins.oe[2] == $past(shared_dir[2]))
		else $error("blue pin not handed back to its latch");

	// first aux deselected: its shared pin follows latch and direction
	aux1_latch_a: assert property (
		sel[AUX1_SEL_BIT] |=> shared_pins.out[3] == $past(shared_latch[3])
			&& shared_pins.oe[3] == $past(shared_dir[3]))
		else $error("aux pin not handed back to its latch");

	// select writes keep only bits that hold state; 0, 1, 6 stay zero
	sel_write_mask_a: assert property (
		sel_write_s |=> state_r.display_pin_select_reg
			== ($past(pwdata[7:0]) & PIN_SEL_MASK))
		else $error("select register write stored wrong bits");

	// a write without its byte strobe leaves every register alone
	strobe_off_a: assert property (
		masked_write_s |=> $stable(state_r.port_direction_reg)
			&& $stable(state_r.display_pin_select_reg))
		else $error("write without strobe changed a register");

	// unmapped access answers with an error and changes nothing
	unmapped_err_a: assert property (
		unmapped_s |=> error_answer_s
			##1 $stable(state_r.port_direction_reg)
			&& $stable(state_r.display_pin_select_reg))
		else $error("unmapped access not refused");
endmodule // dps_pin_config

// ==== testbench/tb_port_direction_and_pin_select.sv ====
/* bench for dps_pin_config: apb master, register model and pin mux model.
   assumes pins settle one clock after their inputs and registers. */
module tb_port_direction_and_pin_select;
	timeunit 1ns;
	timeprecision 1ns;
	import dps_pkg::*;
	logic clock, rst_b, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [ADDR_W-1:0] adr [4];
	logic [31:0] pwdata, prdata, rd, d;
	logic [3:0] pstrb, shared_latch, shared_dir, s;
	logic [2:0][7:0] port_latch;
	logic [4:0] disp;
	logic [7:0] m_reg [4];
	dps_pins_type [2:0] port_pins;
	dps_shared_type shared_pins;
	int fail_count, total_checks, r;
	dps_pin_config i_dps_pin_config (.clock(clock), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_latch(port_latch),
		.shared_latch(shared_latch), .shared_dir(shared_dir),
		.osd_red(disp[0]), .osd_green(disp[1]), .osd_blue(disp[2]),
		.display_aux_out_a(disp[3]), .display_aux_out_b(disp[4]),
		.port_pins(port_pins), .shared_pins(shared_pins));
	// 50 ns period
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task stop_test;
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one transfer; request held until pready seen at an edge
	task apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] dat, input logic [3:0] st);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		pstrb <= st;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		// answer stands in the second access cycle
		check(32'(n), 32'h2);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// random pin inputs; out compared only where the pin drives
	task pins_check;
		logic [7:0] eo, ex;
		logic [3:0] so, sx;
		logic [31:0] got;
		@(posedge clock);
		port_latch <= 24'($urandom);
		shared_latch <= 4'($urandom);
		shared_dir <= 4'($urandom);
		disp <= 5'($urandom);
		@(posedge clock);
		#1;
		for (int p = 0; p < 3; p++) begin
			eo = m_reg[p];
			ex = port_latch[p];
			if (p == 1 && m_reg[3][7]) begin
				eo[0] = 1'b1;
				ex[0] = disp[4];
			end
			got = 32'({port_pins[p].oe, port_pins[p].out & eo});
			check(got, 32'({eo, ex & eo}));
		end
		for (int i = 0; i < 4; i++) begin
			so[i] = m_reg[3][2+i] ? shared_dir[i] : 1'b1;
			sx[i] = m_reg[3][2+i] ? shared_latch[i] : disp[i];
		end
		got = 32'({shared_pins.oe, shared_pins.out & so});
		check(got, 32'({so, sx & so}));
	endtask
	// hang guard, well past the expected run length
	initial begin
		#(5000 * 50);
		fail_count++;
		$display("mismatch at %0t: watchdog", $time);
		stop_test;
	end
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{port_latch, shared_latch, shared_dir, disp} = '0;
		void'($urandom(32'h8c5f7544));
		adr = '{{PORT0_DIR_IDX, 2'b00}, {PORT1_DIR_IDX, 2'b00},
			{PORT2_DIR_IDX, 2'b00}, {PIN_SEL_IDX, 2'b00}};
		m_reg = '{default: 8'h00};
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		// second pass runs after a mid-run reset
		for (int k = 0; k < 2; k++) begin
			for (int j = 0; j < 4; j++) begin
				apb(1'b0, adr[j], 32'h0, 4'hf);
				check(rd, 32'h0);
			end
			pins_check;
			repeat (30) begin
				r = $urandom_range(3);
				d = $urandom;
				// software keeps the two low select bits at zero
				if (r == 3)
					d[1:0] = 2'b00;
				s = 4'($urandom);
				apb(1'b1, adr[r], d, s);
				if (s[0])
					m_reg[r] = d[7:0] & (r == 3 ? PIN_SEL_MASK : 8'hff);
				apb(1'b0, adr[r], 32'h0, 4'hf);
				check(rd, 32'(m_reg[r]));
				pins_check;
			end
			// unmapped word between the direction registers; write ignored
			apb(1'b1, 12'h308, 32'hff, 4'hf);
			check(32'(err), 32'h1);
			apb(1'b0, 12'h308, 32'h0, 4'hf);
			check(32'(err), 32'h1);
			check(rd, 32'h0);
			for (int j = 0; j < 4; j++) begin
				apb(1'b0, adr[j], 32'h0, 4'hf);
				check(rd, 32'(m_reg[j]));
			end
			@(posedge clock);
			rst_b <= 1'b0;
			repeat (2) @(posedge clock);
			rst_b <= 1'b1;
			m_reg = '{default: 8'h00};
		end
		stop_test;
	end
endmodule // tb_port_direction_and_pin_select
